// ==== interrupt_request_enable_bank.sv ====
`timescale 1ns/1ps

module interrupt_request_enable_bank #(
  parameter int ADDR_W = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Peripheral set pulses, one per source
  input wire irq_bank_pkg::src_s src_event,
  // Global interrupt enable from the CPU
  input wire logic global_enable,
  // Requests towards the CPU interrupt logic
  output irq_bank_pkg::src_s cpu_request,
  // Summary interrupt line
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Parameter check

  // Decoder compares twelve address bits
  if (ADDR_W < 12) begin : g_bad_addr_w
    $error("ADDR_W must be at least 12");
  end

  ////////////////////////////////////////////////////////////////////////////
  // State

  // Registered state and its next value
  irq_bank_pkg::bank_state_s s_r;
  irq_bank_pkg::bank_state_s s_nxt;

  // Source events as a plain vector
  logic [7:0] ev;
  // Request flags of both registers
  logic [7:0] flags;
  // Enables of both registers
  logic [7:0] enables;
  // Address phase accepted this cycle
  logic accept;
  // Accepted read of the event status register
  logic rd_status;
  // Low address bits used for decoding
  logic [11:0] addr_lo;

  assign ev = src_event;
  assign addr_lo = haddr[11:0];
  // Flags sit in the upper nibble, enables in the lower
  assign flags = {s_r.periph_reg[7:4], s_r.group_reg[7:4]};
  assign enables = {s_r.periph_reg[3:0], s_r.group_reg[3:0]};
  assign accept = hsel && htrans[1] && hready;
  assign rd_status = accept && !hwrite && (addr_lo == irq_bank_pkg::OFS_EVENT_STATUS);

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  // Bus writes, flag sets, status clear and read data
  always_comb begin
    s_nxt = s_r;
    // Data phase of a write stores the low byte
    if (s_r.dp_wr) begin
      if (s_r.dp_addr == irq_bank_pkg::OFS_GROUP_REG) begin
        s_nxt.group_reg = hwdata[7:0];
      end else if (s_r.dp_addr == irq_bank_pkg::OFS_PERIPH_REG) begin
        s_nxt.periph_reg = hwdata[7:0];
      end else if (s_r.dp_addr == irq_bank_pkg::OFS_EVENT_MASK) begin
        s_nxt.mask = hwdata[7:0];
      end
    end
    // Group flags; a set beats a same-cycle clear
    s_nxt.group_reg[irq_bank_pkg::GROUP_FIVE_REQUEST] =
      s_nxt.group_reg[irq_bank_pkg::GROUP_FIVE_REQUEST] | src_event.group_five;
    s_nxt.group_reg[irq_bank_pkg::GROUP_FOUR_REQUEST] =
      s_nxt.group_reg[irq_bank_pkg::GROUP_FOUR_REQUEST] | src_event.group_four;
    s_nxt.group_reg[irq_bank_pkg::GROUP_THREE_REQUEST] =
      s_nxt.group_reg[irq_bank_pkg::GROUP_THREE_REQUEST] | src_event.group_three;
    s_nxt.group_reg[irq_bank_pkg::GROUP_TWO_REQUEST] =
      s_nxt.group_reg[irq_bank_pkg::GROUP_TWO_REQUEST] | src_event.group_two;
    // Peripheral flags; a set beats a same-cycle clear
    s_nxt.periph_reg[irq_bank_pkg::TIMEBASE_REQUEST] =
      s_nxt.periph_reg[irq_bank_pkg::TIMEBASE_REQUEST] | src_event.timebase;
    s_nxt.periph_reg[irq_bank_pkg::GROUP_SIX_REQUEST] =
      s_nxt.periph_reg[irq_bank_pkg::GROUP_SIX_REQUEST] | src_event.group_six;
    s_nxt.periph_reg[irq_bank_pkg::EEPROM_REQUEST] =
      s_nxt.periph_reg[irq_bank_pkg::EEPROM_REQUEST] | src_event.eeprom;
    s_nxt.periph_reg[irq_bank_pkg::SERIAL_PORT_REQUEST] =
      s_nxt.periph_reg[irq_bank_pkg::SERIAL_PORT_REQUEST] | src_event.serial_port;
    // Sticky event status, cleared by a read, set wins
    if (rd_status) begin
      s_nxt.status = ev;
    end else begin
      s_nxt.status = s_r.status | ev;
    end
    // Address phase capture
    s_nxt.dp_wr = accept && hwrite;
    s_nxt.dp_addr = addr_lo;
    // Read data, forwarded from the values being stored now; status gives its value before the clear
    s_nxt.rdata = 8'h00;
    if (accept && !hwrite) begin
      if (addr_lo == irq_bank_pkg::OFS_GROUP_REG) begin
        s_nxt.rdata = s_nxt.group_reg;
      end else if (addr_lo == irq_bank_pkg::OFS_PERIPH_REG) begin
        s_nxt.rdata = s_nxt.periph_reg;
      end else if (addr_lo == irq_bank_pkg::OFS_EVENT_STATUS) begin
        s_nxt.rdata = s_r.status;
      end else if (addr_lo == irq_bank_pkg::OFS_EVENT_MASK) begin
        s_nxt.rdata = s_nxt.mask;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  // Synchronous reset clears every flag and enable
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_r.group_reg <= irq_bank_pkg::RST_GROUP_REG;
      s_r.periph_reg <= irq_bank_pkg::RST_PERIPH_REG;
      s_r.status <= irq_bank_pkg::RST_EVENT_STATUS;
      s_r.mask <= irq_bank_pkg::RST_EVENT_MASK;
      s_r.dp_wr <= 1'b0;
      s_r.dp_addr <= 12'h000;
      s_r.rdata <= 8'h00;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  // Narrow data in the low byte, upper bits zero
  assign hrdata = {24'h00_0000, s_r.rdata};
  // Per-source request: flag, enable and global enable
  assign cpu_request = flags & enables & {8{global_enable}};
  // Summary line while any unmasked status bit is set
  assign irq = |(s_r.status & s_r.mask);

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // A write reaching its data phase
  sequence s_wr_group;
    s_r.dp_wr && (s_r.dp_addr == irq_bank_pkg::OFS_GROUP_REG);
  endsequence

  sequence s_wr_periph;
    s_r.dp_wr && (s_r.dp_addr == irq_bank_pkg::OFS_PERIPH_REG);
  endsequence

  // Source armed and global enable held over the next edge
  sequence s_armed_tb;
    src_event.timebase && s_nxt.periph_reg[irq_bank_pkg::TIMEBASE_ENABLE]
      && global_enable ##1 global_enable;
  endsequence

  chk_group_five_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.group_five |=> s_r.group_reg[7])
    else $error("group five event did not set its flag");

  chk_group_four_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.group_four |=> s_r.group_reg[6])
    else $error("group four event did not set its flag");

  chk_group_two_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.group_two |=> s_r.group_reg[4])
    else $error("group two event did not set its flag");

  chk_group_enables: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_wr_group |=> s_r.group_reg[3:0] == $past(hwdata[3:0]))
    else $error("group enables not stored from write");

  chk_timebase_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.timebase |=> s_r.periph_reg[7])
    else $error("timebase event did not set its flag");

  chk_group_six_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.group_six |=> s_r.periph_reg[6])
    else $error("group six event did not set its flag");

  chk_eeprom_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.eeprom |=> s_r.periph_reg[5])
    else $error("eeprom event did not set its flag");

  chk_serial_flag: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.serial_port |=> s_r.periph_reg[4])
    else $error("serial port event did not set its flag");

  chk_periph_enables: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_wr_periph |=> s_r.periph_reg[3:0] == $past(hwdata[3:0]))
    else $error("peripheral enables not stored from write");

  chk_group_three: assert property (
    @(posedge ref_clk) disable iff (rst)
    src_event.group_three |=> s_r.group_reg[5] ##1 (cpu_request.group_three
      == (s_r.group_reg[5] && s_r.group_reg[1] && global_enable)))
    else $error("group three flag or enable misplaced");

  chk_reset_clear: assert property (
    @(posedge ref_clk)
    rst |=> (s_r.group_reg == 8'h00) && (s_r.periph_reg == 8'h00))
    else $error("reset left a flag or enable set");

  chk_cpu_request: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_armed_tb |-> cpu_request.timebase)
    else $error("armed timebase source gave no request");

  chk_no_global: assert property (
    @(posedge ref_clk) disable iff (rst)
    !global_enable |-> (cpu_request == 8'h00))
    else $error("request raised with global enable low");

  chk_irq_level: assert property (
    @(posedge ref_clk) disable iff (rst)
    (|(ev & s_nxt.mask)) ##1 (s_r.mask == $past(s_nxt.mask)) |-> irq)
    else $error("unmasked event did not raise irq");

  ////////////////////////////////////////////////////////////////////////////
  // Bus side checks

  // Accepted read of the group register
  sequence s_rd_group;
    accept && !hwrite && (addr_lo == irq_bank_pkg::OFS_GROUP_REG);
  endsequence

  // Accepted read of the peripheral register
  sequence s_rd_periph;
    accept && !hwrite && (addr_lo == irq_bank_pkg::OFS_PERIPH_REG);
  endsequence

  // Accepted read of the mask register
  sequence s_rd_mask;
    accept && !hwrite && (addr_lo == irq_bank_pkg::OFS_EVENT_MASK);
  endsequence

  // Write of the mask register in its data phase
  sequence s_wr_mask;
    s_r.dp_wr && (s_r.dp_addr == irq_bank_pkg::OFS_EVENT_MASK);
  endsequence

  // Accepted read of an offset that maps no register
  sequence s_rd_unmapped;
    accept && !hwrite && (addr_lo != irq_bank_pkg::OFS_GROUP_REG)
      && (addr_lo != irq_bank_pkg::OFS_PERIPH_REG)
      && (addr_lo != irq_bank_pkg::OFS_EVENT_STATUS)
      && (addr_lo != irq_bank_pkg::OFS_EVENT_MASK);
  endsequence

  // Zero wait states and OKAY on every cycle
  chk_bus_okay: assert property (
    @(posedge ref_clk) disable iff (rst)
    hreadyout && !hresp)
    else $error("slave inserted a wait or an error response");

  // Narrow registers leave the upper read lanes at zero
  chk_rdata_upper: assert property (
    @(posedge ref_clk) disable iff (rst)
    hrdata[31:8] == 24'h00_0000)
    else $error("upper read data lanes not zero");

  // Group read returns the value the register holds then
  chk_read_group: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rd_group |=> hrdata[7:0] == s_r.group_reg)
    else $error("group register read data wrong");

  // Peripheral read returns the value the register holds then
  chk_read_periph: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rd_periph |=> hrdata[7:0] == s_r.periph_reg)
    else $error("peripheral register read data wrong");

  // Mask read returns the stored mask
  chk_read_mask: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rd_mask |=> hrdata[7:0] == s_r.mask)
    else $error("mask register read data wrong");

  // Mask write stores the low byte of the data phase
  chk_mask_store: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_wr_mask |=> s_r.mask == $past(hwdata[7:0]))
    else $error("mask not stored from write");

  // Unmapped reads answer zero
  chk_unmapped_zero: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_rd_unmapped |=> hrdata == 32'h0000_0000)
    else $error("unmapped read gave nonzero data");

  ////////////////////////////////////////////////////////////////////////////
  // Flag and status checks

  // A status read with no new event leaves status empty
  chk_status_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    rd_status && (ev == 8'h00) |=> s_r.status == 8'h00)
    else $error("status read did not clear status");

  // Without a read no status bit is lost
  chk_status_sticky: assert property (
    @(posedge ref_clk) disable iff (rst)
    !rd_status |=> ($past(s_r.status) & ~s_r.status) == 8'h00)
    else $error("status bit dropped without a read");

  // Writing zero to idle peripheral flags clears them
  chk_flag_clear: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_wr_periph && (hwdata[7:4] == 4'h0) && (ev[7:4] == 4'h0)
      |=> s_r.periph_reg[7:4] == 4'h0)
    else $error("peripheral flags not cleared by write");

  // Event beats a same-cycle software clear
  chk_set_wins: assert property (
    @(posedge ref_clk) disable iff (rst)
    s_wr_group && !hwdata[7] && src_event.group_five |=> s_r.group_reg[7])
    else $error("software clear beat a group five event");

  // No request leaves the bank straight after reset
  chk_reset_requests: assert property (
    @(posedge ref_clk)
    rst |=> (cpu_request == 8'h00) && !irq)
    else $error("request or irq raised after reset");

endmodule : interrupt_request_enable_bank

// ==== irq_bank_pkg.sv ====
package irq_bank_pkg;

  // Register offsets, byte addresses on the bus
  localparam logic [11:0] OFS_GROUP_REG = 12'h000;
  localparam logic [11:0] OFS_PERIPH_REG = 12'h004;
  localparam logic [11:0] OFS_EVENT_STATUS = 12'h008;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h00C;

  // Bit positions, group register
  localparam int GROUP_FIVE_REQUEST = 7;
  localparam int GROUP_FOUR_REQUEST = 6;
  localparam int GROUP_THREE_REQUEST = 5;
  localparam int GROUP_TWO_REQUEST = 4;
  localparam int GROUP_FIVE_ENABLE = 3;
  localparam int GROUP_FOUR_ENABLE = 2;
  localparam int GROUP_THREE_ENABLE = 1;
  localparam int GROUP_TWO_ENABLE = 0;

  // Bit positions, peripheral register
  localparam int TIMEBASE_REQUEST = 7;
  localparam int GROUP_SIX_REQUEST = 6;
  localparam int EEPROM_REQUEST = 5;
  localparam int SERIAL_PORT_REQUEST = 4;
  localparam int TIMEBASE_ENABLE = 3;
  localparam int GROUP_SIX_ENABLE = 2;
  localparam int EEPROM_ENABLE = 1;
  localparam int SERIAL_PORT_ENABLE = 0;

  // Reset values
  localparam logic [7:0] RST_GROUP_REG = 8'h00;
  localparam logic [7:0] RST_PERIPH_REG = 8'h00;
  localparam logic [7:0] RST_EVENT_STATUS = 8'h00;
  localparam logic [7:0] RST_EVENT_MASK = 8'h00;

  // One bit per interrupt source; low nibble is the group register order
  typedef struct packed {
    logic timebase;
    logic group_six;
    logic eeprom;
    logic serial_port;
    logic group_five;
    logic group_four;
    logic group_three;
    logic group_two;
  } src_s;

  // Whole state of the bank
  typedef struct packed {
    logic [7:0] group_reg;
    logic [7:0] periph_reg;
    logic [7:0] status;
    logic [7:0] mask;
    logic dp_wr;
    logic [11:0] dp_addr;
    logic [7:0] rdata;
  } bank_state_s;

endpackage : irq_bank_pkg

// ==== cpu_irq_model.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
// Core side of the interrupt path: owns the global enable flag
module cpu_irq_model (
  input wire logic ref_clk,
  input wire logic rst,
  // Software request to open or close interrupts
  input wire logic gie_set,
  // Per-source requests presented to the core
  input wire irq_bank_pkg::src_s cpu_request,
  output logic global_enable,
  // Cycles with any request presented
  output logic [7:0] served_count
);
  // Global flag follows software one cycle late, cleared by reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      global_enable <= 1'b0;
      served_count <= 8'h00;
    end else begin
      global_enable <= gie_set;
      if (cpu_request != '0) begin
        served_count <= served_count + 8'h01;
      end
    end
  end
endmodule : cpu_irq_model

// ==== tb_interrupt_request_enable_bank.sv ====
`timescale 1ns/1ps
module tb_interrupt_request_enable_bank;
  logic ref_clk, rst, hsel, hwrite, gie_set, hreadyout, hresp, irq, global_enable;
  logic [11:0] haddr, a;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, q, v;
  irq_bank_pkg::src_s src_event, cpu_request;
  int err_total, check_count, cyc;
  ////////////////////////////////////////////////////////////////////////
  // Block under test, one slave so hready is its own hreadyout
  interrupt_request_enable_bank dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .src_event(src_event), .global_enable(global_enable), .cpu_request(cpu_request),
    .irq(irq));
  // Core model driving the global enable
  cpu_irq_model cpu (.ref_clk(ref_clk), .rst(rst), .gie_set(gie_set),
    .cpu_request(cpu_request), .global_enable(global_enable), .served_count());
  ////////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  // One AHB single transfer, waits on hready in both phases
  task automatic xfer(input logic [11:0] ad, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= ad;
    hwrite <= w;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : xfer
  // Register write
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(ad, 1'b1, d);
  endtask : wr
  // Register read against an expected word
  task automatic rd(input logic [11:0] ad, input logic [31:0] exp, input string nm);
    xfer(ad, 1'b0, 32'h0000_0000);
    check(nm, exp, q);
  endtask : rd
  // One-cycle set pulse on the chosen sources
  task automatic pulse(input logic [7:0] m);
    src_event <= irq_bank_pkg::src_s'(m);
    @(posedge ref_clk);
    src_event <= '0;
    #1;
  endtask : pulse
  // Counts and verdict
  task automatic summarize;
    $display("Checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////
  // Clock, 10 ns period
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    gie_set = 1'b0;
    haddr = 12'h000;
    htrans = 2'b00;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    src_event = '0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rd(irq_bank_pkg::OFS_GROUP_REG, 32'h0000_0000, "group_reg");
    rd(irq_bank_pkg::OFS_PERIPH_REG, 32'h0000_0000, "periph_reg");
    check("irq", 32'h0000_0000, {31'h0, irq});
    check("hresp", 32'h0000_0000, {31'h0, hresp});
    $display("Test reset done");
    // Each source sets its own flag and status bit
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? irq_bank_pkg::OFS_GROUP_REG : irq_bank_pkg::OFS_PERIPH_REG;
      pulse(8'h01 << i);
      rd(a, 32'h0000_0010 << (i % 4), "flag");
      rd(irq_bank_pkg::OFS_EVENT_STATUS, 32'h0000_0001 << i, "status");
      rd(irq_bank_pkg::OFS_EVENT_STATUS, 32'h0000_0000, "status cleared");
      wr(a, 32'h0000_0000);
    end
    $display("Test flag positions done");
    // With the flag held set, enable and global enable gate each request
    for (int i = 0; i < 8; i++) begin
      a = (i < 4) ? irq_bank_pkg::OFS_GROUP_REG : irq_bank_pkg::OFS_PERIPH_REG;
      v = (32'h0000_0011 << (i % 4));
      gie_set <= 1'b1;
      wr(a, v);
      #1;
      check("request on", 32'h0000_0001 << i, {24'h0, cpu_request});
      gie_set <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      check("request global off", 32'h0000_0000, {24'h0, cpu_request});
      gie_set <= 1'b1;
      wr(a, v & 32'h0000_00F0);
      @(posedge ref_clk);
      #1;
      check("request enable off", 32'h0000_0000, {24'h0, cpu_request});
      wr(a, 32'h0000_0000);
    end
    $display("Test enables done");
    // Masked and unmasked events on the summary line
    wr(irq_bank_pkg::OFS_EVENT_MASK, 32'h0000_0020);
    pulse(8'h10);
    check("irq masked", 32'h0000_0000, {31'h0, irq});
    pulse(8'h20);
    check("irq unmasked", 32'h0000_0001, {31'h0, irq});
    rd(irq_bank_pkg::OFS_EVENT_STATUS, 32'h0000_0030, "status pair");
    #1;
    check("irq after clear", 32'h0000_0000, {31'h0, irq});
    rd(irq_bank_pkg::OFS_EVENT_MASK, 32'h0000_0020, "mask");
    wr(12'h010, 32'h0000_00FF);
    rd(12'h010, 32'h0000_0000, "unmapped");
    $display("Test summary line done");
    summarize();
  end
endmodule : tb_interrupt_request_enable_bank
